// ### verilog/dhs_ctl.sv
// drive-side interface control: selection, head stepping, write gating, erase delay and read return
// assumes Avalon-MM master on core_clk; drive pins are asynchronous and synchronised here
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - host selection loads the head and energizes the stepper motor
// - direction one moves the head outward, zero moves it inward
// - each accepted step pulse moves the head exactly one track, except outward on track 0 and inward on track 79
// - two-line mode: step-in pulses move inward, step-out pulses move outward
// - single density default: each accepted step gives two motor step pulses
// - with write gate low, recovered read pulses go back to the host
// - reduced write current when host asks or inner-zone sensor reports
// - protect sensor seeing a protected diskette blocks all writing
// - internal fault stops the write; optionally flagged on the fault output
// - built-in erase delay by default; can be disabled for host erase timing
// - separator fitted: separated data and clock replace the raw read stream
// - during a write, drive write current and write data from host data
// - track-zero output low only with sensor, phase zero and selection together
// - inner-zone output low while the head lies on tracks 43 to 77
module dhs_ctl #(
	parameter int ERASE_DLY_CYC = dhs_pkg::ERASE_DLY_CYC
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output var logic [31:0] avs_readdata,
	output var logic avs_waitrequest,
	output var logic irq,
	input wire dhs_pkg::dhs_pins_in_t pins_in,
	output var dhs_pkg::dhs_pins_out_t pins_out
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	dhs_pkg::dhs_pins_in_t meta_q;
	dhs_pkg::dhs_pins_in_t in_q;
	dhs_pkg::dhs_pins_in_t prev_q;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '0;
			in_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= pins_in;
			in_q <= meta_q;
			prev_q <= in_q;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [6:0] ctrl_q;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_mask_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic irq_q;

	wire sel = in_q.unit_sel;
	wire two_line = ctrl_q[dhs_pkg::CTRL_TWO_LINE];
	wire dbl = ctrl_q[dhs_pkg::CTRL_DOUBLE];
	wire auto_erase = ctrl_q[dhs_pkg::CTRL_AUTO_ERASE];
	wire sep_on = ctrl_q[dhs_pkg::CTRL_SEPARATOR];
	wire fault_out_en = ctrl_q[dhs_pkg::CTRL_FAULT_OUT];
	wire zone_en = ctrl_q[dhs_pkg::CTRL_ZONE_SENSOR];
	wire prot_en = ctrl_q[dhs_pkg::CTRL_PROT_SENSOR];

	// ------------------------------------------------------------
	// step requests
	// ------------------------------------------------------------
	wire step_rise = in_q.step & ~prev_q.step;
	wire in_rise = in_q.step_in & ~prev_q.step_in;
	wire out_rise = in_q.step_out & ~prev_q.step_out;
	wire raw_req = two_line ? (in_rise | out_rise) : step_rise;
	// inward wins if both lines pulse together in two-line mode
	wire req_out = two_line ? (out_rise & ~in_rise) : in_q.dir_out;

	dhs_pkg::dhs_step_st_t st_q, st_d;
	logic [15:0] cnt_q, cnt_d;
	logic [1:0] left_q, left_d;
	logic mdir_q, mdir_d;
	logic [6:0] track_q;
	logic [1:0] phase_q;

	// pulses arriving while a step is still in progress are dropped
	wire step_acc = (st_q == dhs_pkg::ST_IDLE) & sel & raw_req;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		left_d = left_q;
		mdir_d = mdir_q;
		case (st_q)
			dhs_pkg::ST_IDLE: begin
				if (step_acc) begin
					st_d = dhs_pkg::ST_PULSE;
					cnt_d = 16'(dhs_pkg::STEP_PW_CYC - 1);
					left_d = dbl ? 2'h2 : 2'h1;
					mdir_d = req_out;
				end
			end
			dhs_pkg::ST_PULSE: begin
				if (cnt_q == 16'h0) begin
					st_d = dhs_pkg::ST_GAP;
					cnt_d = 16'(dhs_pkg::STEP_GAP_CYC - 1);
					left_d = left_q - 2'h1;
				end else begin
					cnt_d = cnt_q - 16'h1;
				end
			end
			dhs_pkg::ST_GAP: begin
				if (cnt_q == 16'h0) begin
					st_d = (left_q == 2'h0) ? dhs_pkg::ST_IDLE : dhs_pkg::ST_PULSE;
					cnt_d = 16'(dhs_pkg::STEP_PW_CYC - 1);
				end else begin
					cnt_d = cnt_q - 16'h1;
				end
			end
			default: begin
				st_d = dhs_pkg::ST_IDLE;
				cnt_d = 16'h0;
				left_d = 2'h0;
			end
		endcase
	end

	wire pulse_start = (st_q != dhs_pkg::ST_PULSE) & (st_d == dhs_pkg::ST_PULSE);
	wire step_done = (st_q == dhs_pkg::ST_GAP) & (cnt_q == 16'h0) & (left_q == 2'h0);
	wire trk_dec = step_acc & req_out & (track_q != dhs_pkg::TRACK_RST);
	wire trk_inc = step_acc & ~req_out & (track_q != dhs_pkg::TRACK_MAX);
	wire [6:0] track_d = trk_dec ? track_q - 7'h1 : (trk_inc ? track_q + 7'h1 : track_q);
	wire [1:0] phase_d = ~pulse_start ? phase_q : (mdir_d ? phase_q - 2'h1 : phase_q + 2'h1);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= dhs_pkg::ST_IDLE;
			cnt_q <= 16'h0;
			left_q <= 2'h0;
			mdir_q <= 1'b0;
			track_q <= dhs_pkg::TRACK_RST;
			phase_q <= dhs_pkg::PHASE_TRK0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			left_q <= left_d;
			mdir_q <= mdir_d;
			track_q <= track_d;
			phase_q <= phase_d;
		end
	end

	// ------------------------------------------------------------
	// sensors
	// ------------------------------------------------------------
	wire at_trk0 = in_q.trk0_sense & (phase_q == dhs_pkg::PHASE_TRK0) & sel;
	wire in_zone = (track_q >= dhs_pkg::ZONE_LO) & (track_q <= dhs_pkg::ZONE_HI);
	wire reduce = in_q.reduce_in | (zone_en & in_zone);

	// ------------------------------------------------------------
	// write path
	// ------------------------------------------------------------
	logic fault_q;
	logic prot_q;
	logic trk0_prev_q;
	logic [31:0] ecnt_q;

	wire gate_ok = in_q.wr_gate & sel;
	wire prot_blk = prot_en & in_q.prot_sense & gate_ok;
	// stepping while the gate is up counts as improper operation
	wire fault_set = gate_ok & (in_q.cur_fault | (st_q != dhs_pkg::ST_IDLE));
	wire fault_d = fault_set | (fault_q & gate_ok);
	wire wr_act = gate_ok & ~prot_blk & ~fault_d;
	wire [31:0] ecnt_lim = 32'(ERASE_DLY_CYC);
	wire [31:0] ecnt_d = ~wr_act ? 32'h0 : ((ecnt_q < ecnt_lim) ? ecnt_q + 32'h1 : ecnt_q);
	// with auto erase on, erase turns on only after the delay has run with writing active; otherwise it follows ext_erase
	wire erase_d = wr_act & (auto_erase ? (ecnt_q == ecnt_lim) : in_q.ext_erase);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fault_q <= 1'b0;
			prot_q <= 1'b0;
			trk0_prev_q <= 1'b0;
			ecnt_q <= 32'h0;
		end else begin
			fault_q <= fault_d;
			prot_q <= prot_blk;
			trk0_prev_q <= at_trk0;
			ecnt_q <= ecnt_d;
		end
	end

	// ------------------------------------------------------------
	// read path and data separator
	// ------------------------------------------------------------
	logic [15:0] ccnt_q;

	wire rd_pulse = in_q.raw_read & ~prev_q.raw_read & ~in_q.wr_gate;
	// a pulse in the middle of a cell is data, any other one is clock and resyncs the cell
	wire in_win = (ccnt_q >= dhs_pkg::WIN_LO) & (ccnt_q <= dhs_pkg::WIN_HI);
	wire is_clk = rd_pulse & ~in_win;
	wire [15:0] ccnt_d = is_clk ? 16'h0 : ((ccnt_q == 16'hffff) ? ccnt_q : ccnt_q + 16'h1);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ccnt_q <= 16'h0;
		end else begin
			ccnt_q <= ccnt_d;
		end
	end

	// ------------------------------------------------------------
	// pin outputs
	// ------------------------------------------------------------
	dhs_pkg::dhs_pins_out_t out_d;

	always_comb begin
		out_d.head_load = sel;
		out_d.motor_en = sel;
		out_d.motor_step = (st_d == dhs_pkg::ST_PULSE);
		out_d.motor_dir_out = mdir_d;
		out_d.wr_current = wr_act;
		out_d.wr_data = wr_act & in_q.wr_data;
		out_d.erase = erase_d;
		out_d.reduce_cur = reduce & wr_act;
		out_d.read_data = rd_pulse & ~sep_on;
		out_d.sep_data = rd_pulse & sep_on & in_win;
		out_d.sep_clk = is_clk & sep_on;
		out_d.wr_fault = fault_d & fault_out_en;
		out_d.trk0_n = ~at_trk0;
		out_d.zone_n = ~in_zone;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pins_out <= '{trk0_n: 1'b1, zone_n: 1'b1, default: 1'b0};
		end else begin
			pins_out <= out_d;
		end
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	wire [3:0] ev = {prot_blk & ~prot_q, at_trk0 & ~trk0_prev_q, fault_set & ~fault_q, step_done};

	// ------------------------------------------------------------
	// avalon slave: one wait cycle, then a one-cycle answer
	// ------------------------------------------------------------
	wire req = avs_read | avs_write;
	wire wr_en = avs_write & ~wait_q;
	wire wr_ctrl = wr_en & (avs_address == dhs_pkg::OFS_CTRL);
	wire wr_clr = wr_en & (avs_address == dhs_pkg::OFS_IRQ_STAT);
	wire wr_mask = wr_en & (avs_address == dhs_pkg::OFS_IRQ_MASK);
	wire [31:0] status_w = {19'h0, st_q != dhs_pkg::ST_IDLE, wr_act, prot_q, fault_q, sel, 1'b0, track_q};
	wire [3:0] clr_w = wr_clr ? avs_writedata[3:0] : 4'h0;
	// a new event beats a simultaneous clear
	wire [3:0] irq_stat_d = (irq_stat_q & ~clr_w) | ev;
	wire [3:0] irq_mask_d = wr_mask ? avs_writedata[3:0] : irq_mask_q;
	wire [6:0] ctrl_d = wr_ctrl ? avs_writedata[6:0] : ctrl_q;
	wire [31:0] rmux = (avs_address == dhs_pkg::OFS_CTRL) ? {25'h0, ctrl_q} :
		(avs_address == dhs_pkg::OFS_STATUS) ? status_w :
		(avs_address == dhs_pkg::OFS_IRQ_STAT) ? {28'h0, irq_stat_q} :
		(avs_address == dhs_pkg::OFS_IRQ_MASK) ? {28'h0, irq_mask_q} : 32'h0;
	wire [31:0] rdata_d = (avs_read & wait_q) ? rmux : rdata_q;
	wire wait_d = ~(req & wait_q);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= dhs_pkg::CTRL_RST;
			irq_stat_q <= dhs_pkg::IRQ_RST;
			irq_mask_q <= dhs_pkg::IRQ_RST;
			wait_q <= 1'b1;
			rdata_q <= 32'h0;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			irq_q <= |(irq_stat_d & irq_mask_d);
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign irq = irq_q;

endmodule

`default_nettype wire

// ### verilog/dhs_pkg.sv
// shared constants, register map and pin bundles of the drive interface control block
// assumes a single 100 MHz core clock; all drive pins are asynchronous to it
`default_nettype none

package dhs_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int STEP_PW_NS = 1000;
	localparam int STEP_PW_CYC = (STEP_PW_NS * CLK_MHZ + 999) / 1000;
	localparam int STEP_GAP_NS = 3000;
	localparam int STEP_GAP_CYC = (STEP_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int ERASE_DLY_US = 200;
	localparam int ERASE_DLY_CYC = ERASE_DLY_US * CLK_MHZ;
	localparam int CELL_NS = 4000;
	localparam int CELL_CYC = CELL_NS * CLK_MHZ / 1000;
	localparam logic [15:0] WIN_LO = 16'(CELL_CYC / 4);
	localparam logic [15:0] WIN_HI = 16'(CELL_CYC * 3 / 4);

	// ------------------------------------------------------------
	// tracks
	// ------------------------------------------------------------
	localparam logic [6:0] TRACK_RST = 7'h00;
	localparam logic [6:0] TRACK_MAX = 7'h4f;
	localparam logic [6:0] ZONE_LO = 7'h2b;
	localparam logic [6:0] ZONE_HI = 7'h4d;
	localparam logic [1:0] PHASE_TRK0 = 2'h0;

	// ------------------------------------------------------------
	// register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hc;

	localparam int CTRL_TWO_LINE = 0;
	localparam int CTRL_DOUBLE = 1;
	localparam int CTRL_AUTO_ERASE = 2;
	localparam int CTRL_SEPARATOR = 3;
	localparam int CTRL_FAULT_OUT = 4;
	localparam int CTRL_ZONE_SENSOR = 5;
	localparam int CTRL_PROT_SENSOR = 6;
	localparam logic [6:0] CTRL_RST = 7'h06;

	localparam int IRQ_STEP_DONE = 0;
	localparam int IRQ_WR_FAULT = 1;
	localparam int IRQ_TRK0 = 2;
	localparam int IRQ_PROT = 3;
	localparam logic [3:0] IRQ_RST = 4'h0;

	// ------------------------------------------------------------
	// pin bundles
	// ------------------------------------------------------------
	typedef struct packed {
		logic unit_sel;
		logic dir_out;
		logic step;
		logic step_in;
		logic step_out;
		logic wr_gate;
		logic wr_data;
		logic reduce_in;
		logic ext_erase;
		logic prot_sense;
		logic trk0_sense;
		logic cur_fault;
		logic raw_read;
	} dhs_pins_in_t;

	typedef struct packed {
		logic head_load;
		logic motor_en;
		logic motor_step;
		logic motor_dir_out;
		logic wr_current;
		logic wr_data;
		logic erase;
		logic reduce_cur;
		logic read_data;
		logic sep_data;
		logic sep_clk;
		logic wr_fault;
		logic trk0_n;
		logic zone_n;
	} dhs_pins_out_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PULSE,
		ST_GAP
	} dhs_step_st_t;

endpackage

`default_nettype wire

// ### bench/dhs_ctl_checker.sv
// concurrent checks on the ports of the drive interface control block
// bound into dhs_ctl; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module dhs_ctl_checker #(
	parameter int ERASE_DLY_CYC = 20
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic irq,
	input wire dhs_pkg::dhs_pins_in_t pins_in,
	input wire dhs_pkg::dhs_pins_out_t pins_out
);
	// ------------------------------------------------------------
	// control shadow and pulse counters
	// ------------------------------------------------------------
	logic [6:0] ctrl_q;
	int hi_q;
	int wr_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= dhs_pkg::CTRL_RST;
			hi_q <= 0;
			wr_q <= 0;
		end else begin
			if (avs_write && !avs_waitrequest && avs_address == dhs_pkg::OFS_CTRL)
				ctrl_q <= avs_writedata[6:0];
			hi_q <= pins_out.motor_step ? hi_q + 1 : 0;
			wr_q <= pins_out.wr_current ? wr_q + 1 : 0;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	chk_sel_follow: assert property ($stable(pins_in.unit_sel)[*5] |->
		pins_out.head_load == pins_in.unit_sel && pins_out.motor_en == pins_in.unit_sel) else $error("select");
	chk_pulse_width: assert property ($fell(pins_out.motor_step) |-> hi_q == dhs_pkg::STEP_PW_CYC)
		else $error("motor pulse width");
	// direction and the first motor step cycle launch on one edge, so it must hold from the second cycle on
	chk_dir_steady: assert property (pins_out.motor_step && $past(pins_out.motor_step) |->
		$stable(pins_out.motor_dir_out))
		else $error("direction moved in pulse");
	chk_unsel_nowrite: assert property ((!pins_in.unit_sel)[*4] |-> !pins_out.wr_current)
		else $error("write while unselected");
	chk_prot_block: assert property ((pins_in.prot_sense && ctrl_q[6])[*5] |-> !pins_out.wr_current)
		else $error("write on protected disk");
	chk_fault_halt: assert property (pins_in.cur_fault[*5] |-> !pins_out.wr_current)
		else $error("write kept on fault");
	chk_read_quiet: assert property (pins_in.wr_gate[*5] |->
		!(pins_out.read_data || pins_out.sep_data || pins_out.sep_clk)) else $error("read while gated");
	chk_erase_wait: assert property ($rose(pins_out.erase) && ctrl_q[2] |-> wr_q >= ERASE_DLY_CYC - 1)
		else $error("erase too early");
	chk_trk0_free: assert property ((!pins_in.trk0_sense)[*5] |-> pins_out.trk0_n)
		else $error("track zero without sensor");
	chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	cover property ($rose(pins_out.erase));
	cover property ($fell(pins_out.trk0_n));
	cover property ($rose(pins_out.sep_data));
endmodule
bind dhs_ctl dhs_ctl_checker #(.ERASE_DLY_CYC(ERASE_DLY_CYC)) u_chk (.core_clk(core_clk), .nrst(nrst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .pins_in(pins_in), .pins_out(pins_out));
`default_nettype wire

// ### bench/dhs_host_model.sv
// host controller model: select, direction, step and write lines
// driven through its tasks; lines change only right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module dhs_host_model (
	input wire logic core_clk,
	output var logic unit_sel,
	output var logic dir_out,
	output var logic step,
	output var logic step_in,
	output var logic step_out,
	output var logic wr_gate,
	output var logic wr_data,
	output var logic reduce_in
);
	initial begin
		{unit_sel, dir_out, step, step_in, step_out, wr_gate, wr_data, reduce_in} = 8'h00;
	end
	task automatic sel(input logic s);
		@(posedge core_clk);
		unit_sel <= s;
	endtask
	// direction settles well ahead of the step edge that samples it
	task automatic pulse(input logic two, input logic d);
		@(posedge core_clk);
		dir_out <= d;
		repeat (4) @(posedge core_clk);
		step <= !two;
		step_in <= two && !d;
		step_out <= two && d;
		repeat (5) @(posedge core_clk);
		{step, step_in, step_out} <= 3'h0;
	endtask
	task automatic write(input logic on, input logic rd);
		@(posedge core_clk);
		wr_gate <= on;
		reduce_in <= rd;
		repeat (4) @(posedge core_clk);
		wr_data <= on;
	endtask
endmodule
`default_nettype wire

// ### bench/dhs_ctl_tb_top.sv
// self-checking bench for the drive interface control block
// assumes the checker and host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module dhs_ctl_tb_top;
	typedef struct packed {
		logic [6:0] ctrl;
		logic d;
		logic [6:0] trk;
		logic [1:0] np;
	} dhs_row_t;
	// rows are chained so the head ends on track 1 with motor phase 2
	dhs_row_t rows [7] = '{'{7'h06, 1'b0, 7'h01, 2'h2}, '{7'h06, 1'b0, 7'h02, 2'h2},
		'{7'h06, 1'b1, 7'h01, 2'h2}, '{7'h04, 1'b0, 7'h02, 2'h1}, '{7'h05, 1'b0, 7'h03, 2'h1},
		'{7'h05, 1'b1, 7'h02, 2'h1}, '{7'h04, 1'b1, 7'h01, 2'h1}};
	logic core_clk, nrst, avs_read, avs_write, irq, avs_waitrequest;
	logic ers, prot, trk0, flt, rraw;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	wire dhs_pkg::dhs_pins_in_t pins_in;
	dhs_pkg::dhs_pins_out_t pins_out;
	int failures, check_count, mcnt, rd_n, sd_n, sc_n;
	assign {pins_in.ext_erase, pins_in.prot_sense, pins_in.trk0_sense} = {ers, prot, trk0};
	assign {pins_in.cur_fault, pins_in.raw_read} = {flt, rraw};
	dhs_ctl #(.ERASE_DLY_CYC(20)) dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .pins_in(pins_in), .pins_out(pins_out));
	dhs_host_model host (.core_clk(core_clk), .unit_sel(pins_in.unit_sel), .dir_out(pins_in.dir_out),
		.step(pins_in.step), .step_in(pins_in.step_in), .step_out(pins_in.step_out), .wr_gate(pins_in.wr_gate),
		.wr_data(pins_in.wr_data), .reduce_in(pins_in.reduce_in));
	always @(posedge pins_out.motor_step) mcnt++;
	always @(posedge pins_out.read_data) rd_n++;
	always @(posedge pins_out.sep_data) sd_n++;
	always @(posedge pins_out.sep_clk) sc_n++;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// waits as long as the slave needs; only the watchdog ends a hung access
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rp();
		@(posedge core_clk);
		rraw <= 1'b1;
		repeat (3) @(posedge core_clk);
		rraw <= 1'b0;
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#500000;
		failures++;
		stop_test();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{nrst, avs_read, avs_write, ers, prot, trk0, flt, rraw, avs_address, avs_writedata} = '0;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		bus(0, dhs_pkg::OFS_CTRL, 0);
		check(q, 32'h06);
		check(pins_out.head_load, 0);
		host.sel(1'b1);
		repeat (6) @(posedge core_clk);
		check({pins_out.head_load, pins_out.motor_en, pins_out.trk0_n, pins_out.zone_n}, 4'hf);
		foreach (rows[i]) begin
			bus(1, dhs_pkg::OFS_CTRL, 32'(rows[i].ctrl));
			mcnt = 0;
			host.pulse(rows[i].ctrl[0], rows[i].d);
			repeat (900) @(posedge core_clk);
			bus(0, dhs_pkg::OFS_STATUS, 0);
			check(q, {19'h0, 6'h02, rows[i].trk});
			check(mcnt, 32'(rows[i].np));
			check(pins_out.motor_dir_out, rows[i].d);
		end
		// phase 2 on track 1 must not report track zero
		trk0 <= 1'b1;
		repeat (6) @(posedge core_clk);
		check(pins_out.trk0_n, 1);
		bus(1, dhs_pkg::OFS_CTRL, 32'h06);
		host.pulse(0, 1);
		repeat (900) @(posedge core_clk);
		check({pins_out.trk0_n, irq}, 0);
		bus(0, dhs_pkg::OFS_IRQ_STAT, 0);
		check(q, 32'h5);
		bus(1, dhs_pkg::OFS_IRQ_STAT, 32'h1);
		bus(0, dhs_pkg::OFS_IRQ_STAT, 0);
		check(q, 32'h4);
		host.sel(1'b0);
		repeat (6) @(posedge core_clk);
		check({pins_out.trk0_n, pins_out.head_load}, 2'h2);
		mcnt = 0;
		host.pulse(0, 0);
		repeat (900) @(posedge core_clk);
		check(mcnt, 0);
		host.write(1, 1);
		repeat (6) @(posedge core_clk);
		check({pins_out.wr_current, pins_out.wr_data}, 0);
		host.write(0, 0);
		host.sel(1'b1);
		repeat (6) @(posedge core_clk);
		bus(0, dhs_pkg::OFS_STATUS, 0);
		check(q, 32'h100);
		bus(0, 4'h2, 0);
		check(q, 0);
		bus(1, dhs_pkg::OFS_IRQ_MASK, 32'ha);
		bus(1, dhs_pkg::OFS_CTRL, 32'h16);
		host.write(1, 1);
		repeat (8) @(posedge core_clk);
		check({pins_out.wr_current, pins_out.wr_data, pins_out.reduce_cur, pins_out.erase}, 4'he);
		repeat (20) @(posedge core_clk);
		check(pins_out.erase, 1);
		rd_n = 0;
		rp();
		repeat (6) @(posedge core_clk);
		check(rd_n, 0);
		flt <= 1'b1;
		repeat (5) @(posedge core_clk);
		flt <= 1'b0;
		repeat (5) @(posedge core_clk);
		check({pins_out.wr_current, pins_out.wr_fault, irq}, 3'h3);
		host.write(0, 0);
		repeat (6) @(posedge core_clk);
		check({pins_out.wr_current, pins_out.erase, pins_out.wr_fault}, 0);
		bus(1, dhs_pkg::OFS_IRQ_STAT, 32'hf);
		repeat (2) @(posedge core_clk);
		check(irq, 0);
		bus(1, dhs_pkg::OFS_CTRL, 32'h46);
		prot <= 1'b1;
		host.write(1, 0);
		repeat (8) @(posedge core_clk);
		check({pins_out.wr_current, irq}, 2'h1);
		host.write(0, 0);
		prot <= 1'b0;
		bus(1, dhs_pkg::OFS_IRQ_STAT, 32'hf);
		bus(1, dhs_pkg::OFS_CTRL, 32'h02);
		host.write(1, 0);
		ers <= 1'b1;
		repeat (6) @(posedge core_clk);
		check({pins_out.wr_current, pins_out.erase}, 2'h3);
		ers <= 1'b0;
		repeat (5) @(posedge core_clk);
		check(pins_out.erase, 0);
		host.write(0, 0);
		bus(1, dhs_pkg::OFS_CTRL, 32'h06);
		rd_n = 0;
		rp();
		repeat (6) @(posedge core_clk);
		check(rd_n, 1);
		bus(1, dhs_pkg::OFS_CTRL, 32'h0e);
		rp();
		repeat (400) @(posedge core_clk);
		{rd_n, sd_n, sc_n} = '0;
		rp();
		repeat (200) @(posedge core_clk);
		rp();
		repeat (200) @(posedge core_clk);
		rp();
		repeat (6) @(posedge core_clk);
		check({sc_n[3:0], sd_n[3:0], rd_n[3:0]}, 12'h210);
		bus(1, dhs_pkg::OFS_CTRL, 32'h24);
		for (int k = 0; k < 43; k++) begin
			host.pulse(0, 0);
			repeat (420) @(posedge core_clk);
			if (k == 41)
				check(pins_out.zone_n, 1);
		end
		check(pins_out.zone_n, 0);
		host.write(1, 0);
		repeat (8) @(posedge core_clk);
		check(pins_out.reduce_cur, 1);
		host.write(0, 0);
		stop_test();
	end
endmodule
`default_nettype wire
